// ===== core/imwd_regs.svh
`ifndef IMWD_REGS_SVH
`define IMWD_REGS_SVH
// ==========================================================
// Memory window bases (20-bit ISA addresses)
`define IMWD_BASE_LOW 20'hC_8000
`define IMWD_BASE_HIGH 20'hD_0000
// Window is 32 Kbytes: upper address bits 19:15 select it
`define IMWD_WIN_MSB 19
`define IMWD_WIN_LSB 15
// ==========================================================
// I/O port addresses (16-bit)
`define IMWD_IO_POST 16'h0080
`define IMWD_IO_BIOS_PAGE 16'h0120
`define IMWD_IO_STATUS 16'h0120
`define IMWD_IO_DISK_PAGE 16'h0121
`define IMWD_IO_CONTROL 16'h0122
`define IMWD_IO_SRAM_PAGE 16'h0123
// ==========================================================
// Control register fields
`define IMWD_CTL_DECODE 4
`define IMWD_CTL_DISK_WR 3
`define IMWD_CTL_BIOS_WR 2
// ==========================================================
// Reset values
`define IMWD_RST_BYTE 8'h00
`endif

// ===== core/imwd_pkg.sv
`default_nettype none
package imwd_pkg;
  // Region hit inside the window
  typedef enum logic [1:0] {
    IMWD_RGN_NONE = 2'b00,
    IMWD_RGN_BIOS = 2'b01,
    IMWD_RGN_DISK = 2'b10,
    IMWD_RGN_SRAM = 2'b11
  } imwd_region_e;
  typedef logic [7:0] imwd_byte_t;
endpackage : imwd_pkg
`default_nettype wire

// ===== core/imwd_decoder.sv
`timescale 1ns/10ps
`default_nettype none
`include "imwd_regs.svh"

module imwd_decoder (
  input wire logic clk,
  input wire logic reset_n,
  // Asynchronous ISA bus pins
  input wire logic [19:0] isaAddr,
  input wire logic [7:0] isaDataIn,
  input wire logic isaMemRd_n,
  input wire logic isaMemWr_n,
  input wire logic isaIoRd_n,
  input wire logic isaIoWr_n,
  input wire logic baseSelect,
  input wire logic [3:0] switchPack,
  input wire logic flashReady,
  input wire logic diagIochck,
  input wire logic diagNmi,
  // Diagnostic processor read strobe, active low, asynchronous
  input wire logic postRead_n,
  // Bus answer
  output logic memClaim,
  output logic memCs16_n,
  output logic [7:0] isaDataOut,
  output logic isaDataOe,
  // Card memory side
  output imwd_pkg::imwd_region_e region,
  output logic [16:0] biosAddr,
  output logic [20:0] diskAddr,
  output logic [14:0] sramAddr,
  output logic biosWe_n,
  output logic diskWe_n,
  output logic sramWe_n,
  output logic memRd_n,
  // Diagnostic side
  output imwd_pkg::imwd_byte_t postCode,
  output logic post_code_irq
);
  import imwd_pkg::*;

  // ========================================================
  // Pin synchronisers: two flops before any logic looks
  // 20 address bits, 4 strobes, jumper, 4 switches, 3 status lines, read strobe
  logic [32:0] syncA; // First stage, read only by syncB
  logic [32:0] syncB; // Second stage, usable
  wire [32:0] pinsRaw = {isaAddr, isaMemRd_n, isaMemWr_n, isaIoRd_n, isaIoWr_n,
                         baseSelect, switchPack, flashReady, diagIochck, diagNmi,
                         postRead_n};
  // Synchroniser flops; bus data is sampled separately below
  always_ff @(posedge clk) begin
    syncA <= pinsRaw;
    syncB <= syncA;
  end
  logic [7:0] dataA; // Write data first stage
  logic [7:0] dataB; // Write data second stage
  // Data synchroniser
  always_ff @(posedge clk) begin
    dataA <= isaDataIn;
    dataB <= dataA;
  end

  wire [19:0] addr = syncB[32:13];
  wire memRdS = ~syncB[12];
  wire memWrS = ~syncB[11];
  wire ioRdS = ~syncB[10];
  wire ioWrS = ~syncB[9];
  wire baseS = syncB[8];
  wire [3:0] swS = syncB[7:4];
  wire rdyS = syncB[3];
  wire iochkS = syncB[2];
  wire nmiS = syncB[1];
  wire postRdS = ~syncB[0];

  // Edge detect on the io write and diag read strobes so each cycle acts once
  logic ioWrPrev; // Previous io write level
  logic postRdPrev; // Previous diag read level
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ioWrPrev <= 1'b0;
      postRdPrev <= 1'b0;
    end else begin
      ioWrPrev <= ioWrS;
      postRdPrev <= postRdS;
    end
  end
  wire ioWrEdge = ioWrS & ~ioWrPrev;
  wire postRdEdge = postRdS & ~postRdPrev;

  // ========================================================
  // Control registers
  logic [2:0] biosPage; // BIOS page bits 2:0
  logic [7:0] diskPage; // Flash disk page
  logic [1:0] sramPage; // SRAM page
  logic [7:0] control; // Control register, all bits
  wire decodeOn = control[`IMWD_CTL_DECODE];

  function automatic logic ioHit(input logic [19:0] a, input logic [15:0] port);
    ioHit = (a[15:0] == port);
  endfunction : ioHit

  // Register writes; everything clears on reset so decoding starts off
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      biosPage <= 3'b000;
      diskPage <= `IMWD_RST_BYTE;
      sramPage <= 2'b00;
      control <= `IMWD_RST_BYTE;
    end else if (ioWrEdge) begin
      if (ioHit(addr, `IMWD_IO_BIOS_PAGE)) biosPage <= dataB[2:0];
      if (ioHit(addr, `IMWD_IO_DISK_PAGE)) diskPage <= dataB;
      if (ioHit(addr, `IMWD_IO_SRAM_PAGE)) sramPage <= dataB[1:0];
      if (ioHit(addr, `IMWD_IO_CONTROL)) control <= dataB;
    end
  end

  // Port 80 capture; a new write beats a same-cycle read clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      postCode <= `IMWD_RST_BYTE;
      post_code_irq <= 1'b0;
    end else if (ioWrEdge && ioHit(addr, `IMWD_IO_POST)) begin
      postCode <= dataB;
      post_code_irq <= 1'b1;
    end else if (postRdEdge) begin
      post_code_irq <= 1'b0;
    end
  end

  // ========================================================
  // Memory window decode
  wire [19:0] base = baseS ? `IMWD_BASE_HIGH : `IMWD_BASE_LOW;
  wire inWin = addr[`IMWD_WIN_MSB:`IMWD_WIN_LSB] == base[`IMWD_WIN_MSB:`IMWD_WIN_LSB];
  wire [14:0] off = addr[14:0];
  wire memAct = (memRdS | memWrS) & inWin;
  // Offset 4000 and 6000 only split off while decoding is on
  wire diskSel = decodeOn & (off[14:13] == 2'b10);
  wire sramSel = decodeOn & (off[14:13] == 2'b11);
  wire imwd_region_e next_region = !memAct ? IMWD_RGN_NONE :
                                   diskSel ? IMWD_RGN_DISK :
                                   sramSel ? IMWD_RGN_SRAM : IMWD_RGN_BIOS;
  // 32K pages use bits 2:1, 16K pages use bits 2:0
  wire [16:0] next_biosAddr = decodeOn ? {biosPage, off[13:0]}
                                       : {biosPage[2:1], off};
  wire [20:0] next_diskAddr = {diskPage, off[12:0]};
  wire [14:0] next_sramAddr = {sramPage, off[12:0]};
  // Writes gated by the control bits; SRAM always writable
  wire next_biosWe_n = ~(memWrS & (next_region == IMWD_RGN_BIOS)
                         & control[`IMWD_CTL_BIOS_WR]);
  wire next_diskWe_n = ~(memWrS & (next_region == IMWD_RGN_DISK)
                         & control[`IMWD_CTL_DISK_WR]);
  wire next_sramWe_n = ~(memWrS & (next_region == IMWD_RGN_SRAM));

  // Status read-back value and io read decode
  wire statusHit = ioRdS & ioHit(addr, `IMWD_IO_STATUS);
  wire ctrlHit = ioRdS & ioHit(addr, `IMWD_IO_CONTROL);
  wire [7:0] statusVal = {swS, rdyS, 1'b0, iochkS, nmiS};
  wire [7:0] next_dataOut = ctrlHit ? control : statusVal;

  // Registered outputs
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      region <= IMWD_RGN_NONE;
      memClaim <= 1'b0;
      memCs16_n <= 1'b1;
      biosAddr <= 17'h0_0000;
      diskAddr <= 21'h00_0000;
      sramAddr <= 15'h0000;
      biosWe_n <= 1'b1;
      diskWe_n <= 1'b1;
      sramWe_n <= 1'b1;
      memRd_n <= 1'b1;
      isaDataOut <= `IMWD_RST_BYTE;
      isaDataOe <= 1'b0;
    end else begin
      region <= next_region;
      memClaim <= memAct;
      memCs16_n <= 1'b1;
      biosAddr <= next_biosAddr;
      diskAddr <= next_diskAddr;
      sramAddr <= next_sramAddr;
      biosWe_n <= next_biosWe_n;
      diskWe_n <= next_diskWe_n;
      sramWe_n <= next_sramWe_n;
      memRd_n <= ~(memRdS & memAct);
      isaDataOut <= next_dataOut;
      isaDataOe <= statusHit | ctrlHit;
    end
  end

  // ========================================================
  // Assertions
  sequence portWrite_s;
    ioWrEdge && ioHit(addr, `IMWD_IO_POST);
  endsequence
  no_wide_a: assert property (@(posedge clk) disable iff (!reset_n)
    memCs16_n) else $error("16-bit claim");
  claim_win_a: assert property (@(posedge clk) disable iff (!reset_n)
    !memAct |=> !memClaim) else $error("claim outside window");
  post_irq_a: assert property (@(posedge clk) disable iff (!reset_n)
    portWrite_s |=> post_code_irq && postCode == $past(dataB)) else $error("irq not raised");
  irq_clr_a: assert property (@(posedge clk) disable iff (!reset_n)
    postRdEdge && !ioWrEdge |=> !post_code_irq) else $error("irq not cleared");
  disk_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
    !control[`IMWD_CTL_DISK_WR] |=> diskWe_n) else $error("disk write leaked");
  bios_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
    !control[`IMWD_CTL_BIOS_WR] |=> biosWe_n) else $error("bios write leaked");
  fallback_a: assert property (@(posedge clk) disable iff (!reset_n)
    memAct && !decodeOn |=> region == IMWD_RGN_BIOS) else $error("no fallback");
  reset_off_a: assert property (@(posedge clk)
    !reset_n |=> !control[`IMWD_CTL_DECODE] && biosPage == 3'b000) else $error("reset state");
  sram_page_a: assert property (@(posedge clk) disable iff (!reset_n)
    memAct && sramSel |=> region == IMWD_RGN_SRAM && sramAddr[14:13] == $past(sramPage))
    else $error("sram page");
endmodule : imwd_decoder
`default_nettype wire

// ===== verif/imwd_diag_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Diagnostic processor: drains the post code once allowed
module imwd_diag_model (
  input wire logic clk,
  input wire logic en,
  input wire logic post_code_irq,
  input wire logic [7:0] postCode,
  output logic postRead_n,
  output logic [7:0] seen
);
  // Strobe held 4 cycles so the synchroniser cannot miss it
  initial begin
    postRead_n = 1'b1;
    seen = 8'h00;
    forever begin
      @(negedge clk);
      if (en && post_code_irq) begin
        postRead_n = 1'b0;
        repeat (4) @(negedge clk);
        seen = postCode;
        postRead_n = 1'b1;
        repeat (8) @(negedge clk);
      end
    end
  end
endmodule : imwd_diag_model
`default_nettype wire

// ===== verif/imwd_decoder_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "imwd_regs.svh"
// ==========================================
// Bench: ISA cycles driven at the falling edge
module imwd_decoder_tb;
  import imwd_pkg::*;
  localparam logic [19:0] B0 = `IMWD_BASE_LOW;
  localparam logic [19:0] B1 = `IMWD_BASE_HIGH;
  logic clk = 1'b0, reset_n = 1'b0, baseSelect = 1'b0, en = 1'b0;
  logic isaMemRd_n = 1'b1, isaMemWr_n = 1'b1, isaIoWr_n = 1'b1, isaIoRd_n = 1'b1;
  logic [3:0] switchPack = 4'hA;
  logic [19:0] isaAddr = 20'h0_0000;
  logic [7:0] isaDataIn = 8'h00;
  logic memClaim, memCs16_n, isaDataOe, biosWe_n, diskWe_n, sramWe_n, memRd_n;
  logic post_code_irq, postRead_n;
  logic [7:0] isaDataOut, postCode, seen;
  logic [16:0] biosAddr;
  logic [20:0] diskAddr;
  logic [14:0] sramAddr;
  imwd_region_e region;
  int err_count = 0, checks_done = 0, cyc = 0;
  imwd_decoder i_imwd_decoder (.clk, .reset_n, .isaAddr, .isaDataIn, .isaMemRd_n,
    .isaMemWr_n, .isaIoRd_n, .isaIoWr_n, .baseSelect, .switchPack,
    .flashReady(1'b0), .diagIochck(1'b0), .diagNmi(1'b0), .postRead_n, .memClaim,
    .memCs16_n, .isaDataOut, .isaDataOe, .region, .biosAddr, .diskAddr, .sramAddr,
    .biosWe_n, .diskWe_n, .sramWe_n, .memRd_n, .postCode, .post_code_irq);
  imwd_diag_model i_imwd_diag_model (.clk, .en, .post_code_irq, .postCode,
    .postRead_n, .seen);
  always #4 clk = ~clk;
  // Hang guard: whole run needs well under 1000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (!ok) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  // Strobe held 5 cycles, then 4 idle, as the synchroniser needs
  task automatic ioWr(input logic [15:0] p, input logic [7:0] d);
    @(negedge clk);
    isaAddr = {4'h0, p};
    isaDataIn = d;
    isaIoWr_n = 1'b0;
    repeat (5) @(negedge clk);
    isaIoWr_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : ioWr
  // I/O read: data and enable must stand while the strobe does, then drop
  task automatic ioRd(input logic [15:0] p, input logic [7:0] d);
    @(negedge clk);
    isaAddr = {4'h0, p};
    isaIoRd_n = 1'b0;
    repeat (5) @(negedge clk);
    chk(isaDataOe === 1'b1 && isaDataOut === d, "io read");
    isaIoRd_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(isaDataOe === 1'b0, "io read release");
  endtask : ioRd
  task automatic mem(input logic wr, input logic [19:0] a, input imwd_region_e r,
    input logic [20:0] x, input logic we);
    logic [20:0] got;
    @(negedge clk);
    isaAddr = a;
    isaMemRd_n = wr;
    isaMemWr_n = ~wr;
    repeat (5) @(negedge clk);
    got = (r == IMWD_RGN_BIOS) ? {4'h0, biosAddr} :
      (r == IMWD_RGN_DISK) ? diskAddr : {6'h00, sramAddr};
    chk(region === r && memClaim === (r != IMWD_RGN_NONE), "claim");
    chk(memCs16_n === 1'b1, "cs16");
    chk(memRd_n === (wr | (r == IMWD_RGN_NONE)), "read strobe");
    if (r != IMWD_RGN_NONE) begin
      chk(got === x, "address");
    end
    if (wr) begin
      chk(((r == IMWD_RGN_DISK) ? diskWe_n : (r == IMWD_RGN_SRAM) ? sramWe_n : biosWe_n)
        === ~we, "write gate");
    end
    isaMemRd_n = 1'b1;
    isaMemWr_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : mem
  task automatic finish_test();
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    chk(region === IMWD_RGN_NONE && post_code_irq === 1'b0, "reset");
    ioWr(`IMWD_IO_BIOS_PAGE, 8'h07);
    mem(0, B0 + 20'h6123, IMWD_RGN_BIOS, {4'h0, 2'b11, 15'h6123}, 0);
    mem(1, B0 + 20'h0005, IMWD_RGN_BIOS, {4'h0, 2'b11, 15'h0005}, 0);
    mem(0, B1, IMWD_RGN_NONE, 21'h00_0000, 0);
    mem(0, B0 - 20'h0_0001, IMWD_RGN_NONE, 21'h00_0000, 0);
    $display("test decode off done");
    ioRd(`IMWD_IO_STATUS, 8'hA0);
    ioWr(`IMWD_IO_CONTROL, 8'h14);
    ioRd(`IMWD_IO_CONTROL, 8'h14);
    ioWr(`IMWD_IO_DISK_PAGE, 8'hFF);
    ioWr(`IMWD_IO_SRAM_PAGE, 8'h03);
    mem(1, B0 + 20'h3FFF, IMWD_RGN_BIOS, {4'h0, 3'b111, 14'h3FFF}, 1);
    mem(0, B0 + 20'h4000, IMWD_RGN_DISK, {8'hFF, 13'h0000}, 0);
    mem(1, B0 + 20'h5FFF, IMWD_RGN_DISK, {8'hFF, 13'h1FFF}, 0);
    mem(0, B0 + 20'h7FFF, IMWD_RGN_SRAM, {6'h00, 2'b11, 13'h1FFF}, 0);
    mem(1, B0 + 20'h6001, IMWD_RGN_SRAM, {6'h00, 2'b11, 13'h0001}, 1);
    ioWr(`IMWD_IO_CONTROL, 8'h18);
    mem(1, B0 + 20'h4001, IMWD_RGN_DISK, {8'hFF, 13'h0001}, 1);
    baseSelect = 1'b1;
    mem(0, B1 + 20'h6000, IMWD_RGN_SRAM, {6'h00, 2'b11, 13'h0000}, 0);
    mem(0, B0, IMWD_RGN_NONE, 21'h00_0000, 0);
    $display("test decode on done");
    ioWr(`IMWD_IO_POST, 8'hA5);
    chk(postCode === 8'hA5 && post_code_irq === 1'b1, "post write");
    ioWr(`IMWD_IO_POST, 8'h3C);
    chk(postCode === 8'h3C, "post overrun");
    en = 1'b1;
    repeat (16) @(negedge clk);
    chk(post_code_irq === 1'b0 && seen === 8'h3C, "post read");
    $display("test post code done");
    reset_n = 1'b0;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    mem(0, B1 + 20'h4000, IMWD_RGN_BIOS, {4'h0, 2'b00, 15'h4000}, 0);
    $display("test second reset done");
    finish_test();
  end
endmodule : imwd_decoder_tb
`default_nettype wire
